/* File: rtl/cpbc_regs.vh */
// Constants for the crypto peripheral bus controller.
// Assumes inclusion by bare name from design files.
`ifndef CPBC_REGS_VH
`define CPBC_REGS_VH
// Instruction field positions
`define CPBC_INSTR_B0 0
`define CPBC_INSTR_B1 1
`define CPBC_INSTR_B2 2
`define CPBC_INSTR_B3 3
// Sequence counter states {serial_mode, msb, lsb}
`define CPBC_ST_S0 3'h0
`define CPBC_ST_S1 3'h1
`define CPBC_ST_S2 3'h2
`define CPBC_ST_S3 3'h3
`define CPBC_ST_SS1 3'h5
`define CPBC_ST_SS2 3'h6
`define CPBC_ST_SS3 3'h7
// Reset values
`define CPBC_INSTR_RST 4'h0
`define CPBC_DATA_RST 4'h0
// Start drive length in clocks
`define CPBC_START_CYCLES 3'h4
`endif

/* File: rtl/cpbc_buf2.v */
// Two-entry valid/ready buffer for serial output bits.
// Assumes a single clock and active-low asynchronous reset.
`timescale 1ns/1ps
module cpbc_buf2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    // ---------------------------------------------
    // Storage
    // ---------------------------------------------
    reg [WIDTH-1:0] slot0; // Head entry
    reg [WIDTH-1:0] slot1; // Second entry
    reg [1:0] count; // Entries held
    wire push = in_valid && (count != 2'h2);
    wire pop = out_ready && (count != 2'h0);
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = slot0;
    // Shift-register style: head always at slot0
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            slot0 <= {WIDTH{1'b0}};
            slot1 <= {WIDTH{1'b0}};
            count <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'h0) slot0 <= in_data;
                    else slot1 <= in_data;
                    count <= count + 2'h1;
                end
                2'b01: begin
                    slot0 <= slot1;
                    count <= count - 2'h1;
                end
                2'b11: begin
                    if (count == 2'h1) slot0 <= in_data;
                    else begin
                        slot0 <= slot1;
                        slot1 <= in_data;
                    end
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end
endmodule // cpbc_buf2

/* File: rtl/cpbc_ctrl.v */
// Bus controller between a multiplexed-bus processor and a serial crypto chip.
// Assumes bus strobes and the start pin are asynchronous and are synchronised here.
`timescale 1ns/1ps
`include "cpbc_regs.vh"
module cpbc_ctrl (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Processor bus
    input wire addr_latch_en,
    input wire periph_cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire [3:0] bus_data_in,
    output reg [3:0] bus_data_out,
    output reg bus_data_oe,
    // Peripheral chip
    input wire start_in,
    output reg start_out,
    output reg start_oe,
    input wire serial_in,
    output reg serial_out,
    output reg serial_out_valid,
    input wire serial_out_ready,
    input wire strobe_clock_phase,
    output reg serial_strobe_a_n,
    output reg serial_strobe_b_n,
    output reg transfer_select_a_n,
    output reg transfer_select_b_n,
    // Status for observation
    output reg periph_busy
);
    // ---------------------------------------------
    // Input synchronisers
    // ---------------------------------------------
    reg [4:0] sync1; // First stage, read by second only
    reg [4:0] sync2; // Usable stage
    reg [5:0] dsync1; // Data and serial in, first stage
    reg [5:0] dsync2; // Data and serial in, usable stage
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 5'h1e;
            sync2 <= 5'h1e;
            dsync1 <= 6'h00;
            dsync2 <= 6'h00;
        end else begin
            sync1 <= {periph_cs_n, rd_n, wr_n, start_in, addr_latch_en};
            sync2 <= sync1;
            dsync1 <= {strobe_clock_phase, serial_in, bus_data_in};
            dsync2 <= dsync1;
        end
    end
    wire cs_n_s = sync2[4];
    wire rd_n_s = sync2[3];
    wire wr_n_s = sync2[2];
    wire start_s = sync2[1]; // High means idle line
    wire ale_s = sync2[0];
    wire phase_s = dsync2[5];
    wire ser_s = dsync2[4];
    wire [3:0] din_s = dsync2[3:0];
    // ---------------------------------------------
    // Instruction latch
    // ---------------------------------------------
    reg [3:0] instr; // Captured low address bits
    wire instr_latch_bit0 = instr[`CPBC_INSTR_B0];
    wire instr_latch_bit1 = instr[`CPBC_INSTR_B1];
    wire instr_latch_bit2 = instr[`CPBC_INSTR_B2];
    wire instr_latch_bit3 = instr[`CPBC_INSTR_B3];
    // Load on selected latch enable, else hold
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            instr <= `CPBC_INSTR_RST;
        end else if (ale_s && !cs_n_s) begin
            instr <= din_s;
        end
    end
    // ---------------------------------------------
    // Sequence counter, start drive, selects
    // ---------------------------------------------
    reg [2:0] seq; // Buried state, never on a pin
    reg [2:0] next_seq;
    reg [2:0] start_cnt; // Clocks of start drive so far
    wire counting = (seq != `CPBC_ST_S0);
    wire seq_counter_lsb = seq[0];
    wire seq_counter_msb = seq[1];
    // Start counts as true while we drive it or chip holds it low
    wire start_true = start_oe || !start_s;
    // Next counter state
    always @* begin
        next_seq = seq;
        case (seq)
            `CPBC_ST_S0: begin
                // Count only once our own drive has let go, so the serial count never overlaps the drive
                if (instr_latch_bit3 && start_true && !start_oe) next_seq = `CPBC_ST_SS1;
                else if (instr_latch_bit2) next_seq = `CPBC_ST_S1;
                else if (instr_latch_bit0) next_seq = `CPBC_ST_S1;
            end
            `CPBC_ST_S1: next_seq = `CPBC_ST_S2;
            `CPBC_ST_S2: next_seq = `CPBC_ST_S3;
            `CPBC_ST_S3: next_seq = `CPBC_ST_S0;
            `CPBC_ST_SS1: next_seq = `CPBC_ST_SS2;
            `CPBC_ST_SS2: next_seq = `CPBC_ST_SS3;
            `CPBC_ST_SS3: next_seq = `CPBC_ST_S0;
            default: next_seq = `CPBC_ST_S0;
        endcase
    end
    // Selects hold while counting and not at the last count
    wire hold_ok = counting && (!seq_counter_lsb || !seq_counter_msb);
    wire next_sel_a = (instr_latch_bit2 && instr_latch_bit0 && start_true)
        || (hold_ok && !transfer_select_a_n);
    wire next_sel_b = (instr_latch_bit1 && instr_latch_bit2 && start_true)
        || (hold_ok && !transfer_select_b_n);
    // Launch only from idle with the line high; a held write or busy chip cannot retrigger
    wire launch_ok = !counting && (start_cnt == 3'h0) && start_s;
    // Counter, selects, start drive and busy flop
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            seq <= `CPBC_ST_S0;
            transfer_select_a_n <= 1'b1;
            transfer_select_b_n <= 1'b1;
            serial_strobe_a_n <= 1'b1;
            serial_strobe_b_n <= 1'b1;
            start_out <= 1'b1;
            start_oe <= 1'b0;
            start_cnt <= 3'h0;
            periph_busy <= 1'b0;
        end else begin
            seq <= next_seq;
            transfer_select_a_n <= !next_sel_a;
            transfer_select_b_n <= !next_sel_b;
            // Strobes pulse only in low strobe phase
            serial_strobe_a_n <= !(next_sel_a && !phase_s);
            serial_strobe_b_n <= !(next_sel_b && !phase_s);
            // Launch: a selected write with bit3 set arms a four-clock drive
            if (launch_ok && !cs_n_s && !wr_n_s && instr_latch_bit3) begin
                start_oe <= 1'b1;
                start_out <= 1'b0;
                start_cnt <= 3'h1;
            end else if (start_oe && start_cnt == `CPBC_START_CYCLES) begin
                start_oe <= 1'b0;
                start_out <= 1'b1;
                start_cnt <= 3'h0;
            end else if (start_oe) begin
                start_cnt <= start_cnt + 3'h1;
            end
            // Busy: set when idle, or counting with the pin low; chip holds it low
            periph_busy <= !counting || !start_s;
        end
    end
    // ---------------------------------------------
    // Shift data register and serial output path
    // ---------------------------------------------
    reg [3:0] shift_data; // Parallel-to-serial converter
    wire shift_data_bit3 = shift_data[3];
    wire any_strobe = !transfer_select_a_n || !transfer_select_b_n
        || !serial_strobe_a_n || !serial_strobe_b_n;
    wire buf_in_ready;
    wire buf_out_valid;
    wire buf_out_data;
    // Shifting stalls when the output buffer is full
    wire do_shift = any_strobe && buf_in_ready;
    // Output stage takes a new bit when empty or when its bit is being taken
    wire buf_pop_ok = !serial_out_valid || serial_out_ready;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            shift_data <= `CPBC_DATA_RST;
        end else if (!cs_n_s && !wr_n_s) begin
            shift_data <= din_s;
        end else if (do_shift) begin
            shift_data <= {shift_data[2:0], ser_s};
        end
    end
    cpbc_buf2 #(.WIDTH(1)) u_buf (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(do_shift),
        .in_ready(buf_in_ready),
        .in_data(shift_data_bit3),
        .out_valid(buf_out_valid),
        .out_ready(buf_pop_ok),
        .out_data(buf_out_data)
    );
    // Registered serial output stage; a stalled bit stands until taken
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serial_out <= 1'b0;
            serial_out_valid <= 1'b0;
        end else if (buf_pop_ok) begin
            serial_out <= buf_out_data;
            serial_out_valid <= buf_out_valid;
        end
    end
    // ---------------------------------------------
    // Read-back mux
    // ---------------------------------------------
    wire y_state = (seq == `CPBC_ST_SS1) || (seq == `CPBC_ST_SS2);
    wire x_state = (seq == `CPBC_ST_S1) || (seq == `CPBC_ST_S2);
    reg [3:0] next_rdata;
    always @* begin
        next_rdata = 4'h0;
        if (instr_latch_bit0 && !instr_latch_bit2) begin
            next_rdata = shift_data;
        end else if (!instr_latch_bit0 && !instr_latch_bit2) begin
            next_rdata[0] = !serial_strobe_a_n || y_state;
            next_rdata[1] = !serial_strobe_b_n;
            next_rdata[2] = x_state || !serial_strobe_a_n || !serial_strobe_b_n;
            next_rdata[3] = periph_busy;
        end
    end
    // Drive only during a selected read
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bus_data_out <= 4'h0;
            bus_data_oe <= 1'b0;
        end else begin
            bus_data_out <= next_rdata;
            bus_data_oe <= !cs_n_s && !rd_n_s;
        end
    end
endmodule // cpbc_ctrl

/* File: test/cpbc_props.sv */
// Port checker for the bus controller.
// Assumes a bind from the bench top and one clock domain.
`timescale 1ns/1ps
module cpbc_props (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Watched ports
    input wire periph_cs_n,
    input wire rd_n,
    input wire bus_data_oe,
    input wire start_out,
    input wire start_oe,
    input wire serial_out,
    input wire serial_out_valid,
    input wire serial_out_ready,
    input wire transfer_select_a_n,
    input wire transfer_select_b_n,
    input wire serial_strobe_a_n,
    input wire serial_strobe_b_n
);
// ----------
// Properties
// ----------
default clocking cb @(posedge core_clk); endclocking
default disable iff (!nrst);
// Two sampling lags allowed for the input synchronisers
a_oe_only_read: assert property (bus_data_oe |->
    (!$past(periph_cs_n, 2) || !$past(periph_cs_n, 3)) && (!$past(rd_n, 2) || !$past(rd_n, 3)))
    else $error("bus driven outside a selected read");
a_oe_on_read: assert property ((!rd_n && !periph_cs_n) [*4] |-> bus_data_oe)
    else $error("selected read not driven");
a_strobe_a_gate: assert property (!serial_strobe_a_n |->
    !transfer_select_a_n || !$past(transfer_select_a_n)) else $error("strobe a without select");
a_strobe_b_gate: assert property (!serial_strobe_b_n |->
    !transfer_select_b_n || !$past(transfer_select_b_n)) else $error("strobe b without select");
a_start_low: assert property (start_oe |-> !start_out)
    else $error("start driven high");
a_start_hold: assert property ($rose(start_oe) |-> start_oe [*4])
    else $error("start drive too short");
a_start_free: assert property ($rose(start_oe) |-> ##[4:6] !start_oe)
    else $error("start drive not released");
// A stalled bit must wait unchanged
a_buf_hold: assert property (serial_out_valid && !serial_out_ready |=>
    serial_out_valid && $stable(serial_out)) else $error("stalled bit lost");
endmodule // cpbc_props

/* File: test/cpbc_chip.sv */
// Model of the serial crypto chip behind the controller.
// Assumes the start wire has a pull-up and one system clock.
`timescale 1ns/1ps
module cpbc_chip #(
    parameter HOLD = 400
) (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Start wire
    input wire start_oe,
    input wire start_out,
    output wire start_in,
    // Serial path
    output reg serial_in,
    input wire serial_out,
    input wire serial_out_valid,
    output reg serial_out_ready,
    output reg [7:0] rx_count
);
reg [9:0] hold; // Cycles left of own busy drive
reg was_oe; // Controller drove start last cycle
// Chip takes over the low level at release, pull-up otherwise
assign start_in = start_oe ? start_out : ((was_oe || hold != 10'h0) ? 1'b0 : 1'b1);
// Busy hold, stalling receiver and serial input toggle
always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
        hold <= 10'h0;
        was_oe <= 1'b0;
        serial_in <= 1'b0;
        serial_out_ready <= 1'b0;
        rx_count <= 8'h0;
    end else begin
        was_oe <= start_oe;
        if (was_oe && !start_oe) begin
            hold <= HOLD;
        end else if (hold != 10'h0) begin
            hold <= hold - 10'h1;
        end
        // Ready every other cycle, so the buffer sees stalls
        serial_out_ready <= !serial_out_ready;
        serial_in <= !serial_in;
        if (serial_out_valid && serial_out_ready) begin
            rx_count <= rx_count + 8'h1;
        end
    end
end
endmodule // cpbc_chip

/* File: test/tb_top.sv */
// Self-checking bench for the bus controller.
// Assumes the chip model on the far side and a bound checker.
`timescale 1ns/1ps
module tb_top;
// Bench-driven inputs
reg core_clk = 0, nrst = 0, addr_latch_en = 0, periph_cs_n = 1, rd_n = 1, wr_n = 1;
reg strobe_clock_phase = 0;
reg [3:0] bus_data_in = 4'h0;
// Design outputs and model wires
wire [3:0] bus_data_out;
wire bus_data_oe, start_in, start_out, start_oe, serial_in, serial_out, serial_out_valid;
wire serial_out_ready, serial_strobe_a_n, serial_strobe_b_n, periph_busy;
wire transfer_select_a_n, transfer_select_b_n;
wire [7:0] rx_count;
integer n_mismatch = 0, n_checks = 0, cycles = 0, i;
reg [3:0] rd_val, oe_len; // Last read value, start drive length
reg seen_a, seen_b; // Select activity since last clear
reg [7:0] rx0;
cpbc_ctrl uut (.core_clk, .nrst, .addr_latch_en, .periph_cs_n, .rd_n, .wr_n, .bus_data_in,
    .bus_data_out, .bus_data_oe, .start_in, .start_out, .start_oe, .serial_in, .serial_out,
    .serial_out_valid, .serial_out_ready, .strobe_clock_phase, .serial_strobe_a_n,
    .serial_strobe_b_n, .transfer_select_a_n, .transfer_select_b_n, .periph_busy);
cpbc_chip chip (.core_clk, .nrst, .start_oe, .start_out, .start_in, .serial_in, .serial_out,
    .serial_out_valid, .serial_out_ready, .rx_count);
initial begin
    forever #10 core_clk = ~core_clk;
end
// Timeout, slow strobe phase and observers
always @(posedge core_clk) begin
    cycles <= cycles + 1;
    strobe_clock_phase <= cycles[1];
    oe_len <= oe_len + start_oe;
    seen_a <= seen_a | !transfer_select_a_n;
    seen_b <= seen_b | !transfer_select_b_n;
    if (cycles == 4000) begin
        n_mismatch = n_mismatch + 1;
        final_report;
    end
end
task chk(input [8*8-1:0] name, input [3:0] exp, input [3:0] got);
    begin
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %0s expected %h seen %h", name, exp, got);
        end
    end
endtask
// Latch an instruction, then one write or read; long phases cover the syncs
task bus(input [3:0] ins, input wr, input [3:0] d);
    begin
        @(posedge core_clk);
        addr_latch_en <= 1; periph_cs_n <= 0; bus_data_in <= ins;
        repeat (4) @(posedge core_clk);
        addr_latch_en <= 0; periph_cs_n <= 1;
        repeat (2) @(posedge core_clk);
        periph_cs_n <= 0; wr_n <= !wr; rd_n <= wr; bus_data_in <= wr ? d : ~ins;
        repeat (6) @(posedge core_clk);
        #1 rd_val = bus_data_oe ? bus_data_out : 4'hx;
        @(posedge core_clk);
        periph_cs_n <= 1; wr_n <= 1; rd_n <= 1; bus_data_in <= ~bus_data_in;
        repeat (6) @(posedge core_clk);
    end
endtask
task t_data;
    begin
        for (i = 0; i < 2; i = i + 1) begin
            bus(4'h1, 1, i ? 4'h5 : 4'ha);
            bus(4'h1, 0, 4'h0);
            chk("data", i ? 4'h5 : 4'ha, rd_val);
        end
        bus(4'h4, 0, 4'h0);
        chk("refused", 4'h0, rd_val);
    end
endtask
task t_launch;
    begin
        #1 oe_len = 4'h0;
        bus(4'h8, 1, 4'h0);
        chk("startlen", 4'h4, oe_len);
        chk("pinlow", 4'h0, {3'h0, start_in});
        bus(4'h0, 0, 4'h0);
        chk("status", 4'h8, rd_val);
    end
endtask
task t_xfer;
    begin
        for (i = 0; i < 2; i = i + 1) begin
            bus(4'h0, 0, 4'h0);
            chk("idle", 4'h8, rd_val);
            #1 seen_a = 0; seen_b = 0; rx0 = rx_count;
            bus(i ? 4'h6 : 4'h5, 1, 4'hc);
            chk("select", i ? 4'h2 : 4'h1, {2'h0, seen_b, seen_a});
            chk("serial", 4'h1, {3'h0, rx_count != rx0});
        end
    end
endtask
task final_report;
    begin
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    end
endtask
initial begin
    oe_len = 4'h0; seen_a = 0; seen_b = 0;
    repeat (2) @(posedge core_clk);
    nrst <= 1;
    repeat (3) @(posedge core_clk);
    #1 chk("reset", 4'h3, {bus_data_oe, start_oe, transfer_select_a_n, transfer_select_b_n});
    chk("busy", 4'h1, {3'h0, periph_busy});
    t_data;
    t_launch;
    t_xfer;
    final_report;
end
endmodule // tb_top
bind cpbc_ctrl cpbc_props u_props (.core_clk, .nrst, .periph_cs_n, .rd_n, .bus_data_oe,
    .start_out, .start_oe, .serial_out, .serial_out_valid, .serial_out_ready,
    .transfer_select_a_n, .transfer_select_b_n, .serial_strobe_a_n, .serial_strobe_b_n);
